// file: verilog/dds_core_cfg.svh
// Constant definitions for the synthesis core
`ifndef DDS_CORE_CFG_SVH
`define DDS_CORE_CFG_SVH

`define MODE_WIDTH 4
`define MODE_RESET 4'h0
`define MODE_BUS16_BIT 0
`define MODE_SLEEP_BIT 1
`define MODE_AMP_BIT 2
`define MODE_BYPASS_BIT 3

`define WORD_WIDTH 32
`define PIN_DATA_WIDTH 16
`define NARROW_SHIFT 8
`define WIDE_SHIFT 16
`define PHASE_WIDTH 12
`define PHASE_LSB 20
`define AMP_WIDTH 10
`define QUAD_WIDTH 20
`define QUAD_Q_LSB 10
`define TC_WIDTH 4

`define CTL_STAGES 4
`define CTL_WIDTH 6
`define CTL_FSEL_BIT 0
`define CTL_LOAD_BIT 1
`define CTL_TC_LSB 2
`define BYPASS_STAGE 1

`define TC_MOD_BIT 3
`define TC_SERIAL_BIT 2
`define TC_SERIAL_STEP_B 4'hd

`define SER_QUIET_CYCLES 3'h3
`define SER_QUIET_WIDTH 3

`define LUT_HALF_SPAN 12'h800
`define LUT_QUARTER 12'h400
`define LUT_PEAK 9'h1ff

`endif

// file: verilog/dds_core_pkg.sv
// Types shared by the synthesis core files
package dds_core_pkg;
    typedef enum logic [1:0] {dest_step_a, dest_step_b, dest_phase, dest_amp} xfer_dest_t;
    typedef logic signed [9:0] sample_t;
endpackage

// file: verilog/sine_table.sv
// Sine and cosine lookup with registered outputs
`timescale 1ns/1ps
`default_nettype none
`include "dds_core_cfg.svh"

module sine_table
    import dds_core_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [11:0] addr_in,
    output sample_t sin_out,
    output sample_t cos_out
);

    // Parabolic half-wave; cheaper than a full stored table, a few percent of distortion
    function automatic sample_t wave(input logic [11:0] a);
        logic [21:0] prod;
        logic [10:0] x;
        logic [8:0] mag;
        x = a[10:0];
        prod = {11'h000, x} * {11'h000, (11'h7ff - x)};
        mag = (prod[21:11] > {2'b00, `LUT_PEAK}) ? `LUT_PEAK : prod[19:11];
        wave = a[11] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    endfunction

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sin_out <= '0;
            cos_out <= '0;
        end else begin
            sin_out <= wave(addr_in);
            cos_out <= wave(addr_in + `LUT_QUARTER);
        end
    end

endmodule // sine_table
`default_nettype wire

// file: verilog/dds_core.sv
// Synthesis core: loading paths, accumulator, modulators
`timescale 1ns/1ps
`default_nettype none
`include "dds_core_cfg.svh"

module dds_core
    import dds_core_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [15:0] data_in,
    input wire logic write_strobe_n_in,
    input wire logic chip_select_n_in,
    input wire logic load_in,
    input wire logic [3:0] transfer_code_in,
    input wire logic freq_choice_pin_in,
    input wire logic serial_bit_clock_in,
    input wire logic serial_data_in,
    output logic [9:0] dac_out,
    output logic sleep_out
);

    logic [3:0] mode_control_reg;
    logic [1:0] wr_sync_reg, cs_sync_reg;
    logic [15:0] data_sync1_reg, data_sync2_reg, par_hold_reg;
    logic wr_prev_reg, cs_prev_reg, write_end;
    logic [31:0] par_asm_reg;
    logic [31:0] ser_shift_reg;
    logic ser_toggle_reg;
    logic [2:0] ser_tog_sync_reg;
    logic [2:0] ser_quiet_reg;
    logic [31:0] ser_copy_reg;
    logic [5:0] ctl_pipe_reg [0:3];
    logic [5:0] ctl_used;
    logic load_prev_reg, load_rise;
    logic [3:0] tc_used;
    xfer_dest_t dest;
    logic [31:0] xfer_src;
    logic [31:0] step_word_a_reg, step_word_b_reg, acc_reg;
    logic [11:0] phase_offset_reg;
    logic [19:0] quad_amplitude_word_reg;
    logic [11:0] lut_addr;
    sample_t sin_val, cos_val;
    logic signed [19:0] i_prod, q_prod;
    logic [9:0] iq_sum;
    logic bus16, sleeping, amp_on, bypass;

    assign bus16 = mode_control_reg[`MODE_BUS16_BIT];
    assign sleeping = mode_control_reg[`MODE_SLEEP_BIT];
    assign amp_on = mode_control_reg[`MODE_AMP_BIT];
    assign bypass = mode_control_reg[`MODE_BYPASS_BIT];

    // Parallel pins are asynchronous to the core clock
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            wr_sync_reg <= 2'h3;
            cs_sync_reg <= 2'h3;
            data_sync1_reg <= '0;
            data_sync2_reg <= '0;
            wr_prev_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            wr_sync_reg <= {wr_sync_reg[0], write_strobe_n_in};
            cs_sync_reg <= {cs_sync_reg[0], chip_select_n_in};
            data_sync1_reg <= data_in;
            data_sync2_reg <= data_sync1_reg;
            wr_prev_reg <= wr_sync_reg[1];
            cs_prev_reg <= cs_sync_reg[1];
        end
    end

    // Write ends when the strobe returns high after a selected low phase
    assign write_end = !wr_prev_reg && !cs_prev_reg && wr_sync_reg[1];

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            par_hold_reg <= '0;
        end else if (!wr_sync_reg[1] && !cs_sync_reg[1]) begin
            par_hold_reg <= data_sync2_reg;
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            par_asm_reg <= '0;
        end else if (write_end) begin
            if (bus16) begin
                par_asm_reg <= {par_asm_reg[15:0], par_hold_reg};
            end else begin
                par_asm_reg <= {par_asm_reg[23:0], par_hold_reg[7:0]};
            end
        end
    end

    // Serial link logic runs on its own clock
    always_ff @(posedge serial_bit_clock_in or posedge reset_in) begin
        if (reset_in) begin
            ser_shift_reg <= '0;
            ser_toggle_reg <= 1'b0;
        end else begin
            ser_shift_reg <= {ser_shift_reg[30:0], serial_data_in};
            ser_toggle_reg <= !ser_toggle_reg;
        end
    end

    // Word taken once per burst after a quiet spell; copying while the bit clock runs would tear it
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ser_tog_sync_reg <= '0;
            ser_quiet_reg <= '0;
            ser_copy_reg <= '0;
        end else begin
            ser_tog_sync_reg <= {ser_tog_sync_reg[1:0], ser_toggle_reg};
            if (ser_tog_sync_reg[2] != ser_tog_sync_reg[1]) begin
                ser_quiet_reg <= '0;
            end else if (ser_quiet_reg != `SER_QUIET_CYCLES) begin
                ser_quiet_reg <= ser_quiet_reg + 3'h1;
            end
            if (ser_quiet_reg == (`SER_QUIET_CYCLES - 3'h1) && ser_tog_sync_reg[2] == ser_tog_sync_reg[1]) begin
                ser_copy_reg <= ser_shift_reg;
            end
        end
    end

    // Control pin pipeline; first two stages always act as the synchroniser
    generate
        for (genvar s = 0; s < `CTL_STAGES; s++) begin : g_ctl
            if (s == 0) begin : g_first
                always_ff @(posedge sys_clk_in or posedge reset_in) begin
                    if (reset_in) begin
                        ctl_pipe_reg[s] <= '0;
                    end else begin
                        ctl_pipe_reg[s] <= {transfer_code_in, load_in, freq_choice_pin_in};
                    end
                end
            end else begin : g_rest
                always_ff @(posedge sys_clk_in or posedge reset_in) begin
                    if (reset_in) begin
                        ctl_pipe_reg[s] <= '0;
                    end else begin
                        ctl_pipe_reg[s] <= ctl_pipe_reg[s - 1];
                    end
                end
            end
        end
    endgenerate

    // Bypass trades metastability margin for two cycles of latency
    assign ctl_used = bypass ? ctl_pipe_reg[`BYPASS_STAGE] : ctl_pipe_reg[`CTL_STAGES - 1];
    assign tc_used = ctl_used[`CTL_TC_LSB +: `TC_WIDTH];
    assign load_rise = ctl_used[`CTL_LOAD_BIT] && !load_prev_reg;
    assign dest = xfer_dest_t'(tc_used[1:0]);
    assign xfer_src = tc_used[`TC_SERIAL_BIT] ? ser_copy_reg : par_asm_reg;

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            load_prev_reg <= 1'b0;
        end else begin
            load_prev_reg <= ctl_used[`CTL_LOAD_BIT];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            mode_control_reg <= `MODE_RESET;
        end else if (load_rise && !tc_used[`TC_MOD_BIT]) begin
            mode_control_reg <= par_asm_reg[`MODE_WIDTH - 1:0];
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            step_word_a_reg <= '0;
            step_word_b_reg <= '0;
            phase_offset_reg <= '0;
            quad_amplitude_word_reg <= '0;
        end else if (load_rise && tc_used[`TC_MOD_BIT]) begin
            unique case (dest)
                dest_step_a: step_word_a_reg <= xfer_src;
                dest_step_b: step_word_b_reg <= xfer_src;
                dest_phase: phase_offset_reg <= xfer_src[`PHASE_WIDTH - 1:0];
                dest_amp: quad_amplitude_word_reg <= xfer_src[`QUAD_WIDTH - 1:0];
            endcase
        end
    end

    // Sleep freezes the accumulator in place of gating the clock
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            acc_reg <= '0;
        end else if (!sleeping) begin
            acc_reg <= acc_reg + (ctl_used[`CTL_FSEL_BIT] ? step_word_b_reg : step_word_a_reg);
        end
    end

    assign lut_addr = acc_reg[`WORD_WIDTH - 1:`PHASE_LSB] + phase_offset_reg;

    sine_table u_table (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .addr_in(lut_addr),
        .sin_out(sin_val),
        .cos_out(cos_val)
    );

    assign i_prod = cos_val * $signed(quad_amplitude_word_reg[`AMP_WIDTH - 1:0]);
    assign q_prod = sin_val * $signed(quad_amplitude_word_reg[`QUAD_WIDTH - 1:`QUAD_Q_LSB]);
    // No clipping: the sum rolls over
    assign iq_sum = i_prod[18:9] + q_prod[18:9];

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            dac_out <= '0;
            sleep_out <= 1'b0;
        end else begin
            sleep_out <= sleeping;
            if (sleeping) begin
                dac_out <= '0;
            end else if (amp_on) begin
                dac_out <= iq_sum;
            end else begin
                dac_out <= sin_val;
            end
        end
    end

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence load_seen_slow;
        $rose(ctl_pipe_reg[0][`CTL_LOAD_BIT]) ##0 (!bypass)[*4];
    endsequence

    sequence load_seen_fast;
        bypass && $rose(ctl_pipe_reg[`BYPASS_STAGE][`CTL_LOAD_BIT]) && !load_prev_reg;
    endsequence

    narrow_shift_a: assert property (write_end && !bus16 |=>
        par_asm_reg == {$past(par_asm_reg[23:0]), $past(par_hold_reg[7:0])})
        else $error("narrow write shift wrong");
    wide_shift_a: assert property (write_end && bus16 |=>
        par_asm_reg == {$past(par_asm_reg[15:0]), $past(par_hold_reg)})
        else $error("wide write shift wrong");
    sleep_freeze_a: assert property (sleeping |=> $stable(acc_reg) && dac_out == 10'h000)
        else $error("sleep did not freeze output");
    amp_bypass_a: assert property (!sleeping && !amp_on |=> dac_out == $past(sin_val))
        else $error("bypass output not sine");
    sync_latency_a: assert property (load_seen_slow |-> load_rise)
        else $error("load not seen after four stages");
    bypass_latency_a: assert property (load_seen_fast |-> load_rise)
        else $error("bypassed load not seen");
    mode_source_a: assert property ($changed(mode_control_reg) |->
        $past(load_rise && !tc_used[`TC_MOD_BIT]) && mode_control_reg == $past(par_asm_reg[3:0]))
        else $error("mode changed without parallel transfer");
    acc_step_a: assert property (!sleeping |=> acc_reg == $past(acc_reg) +
        ($past(ctl_used[`CTL_FSEL_BIT]) ? $past(step_word_b_reg) : $past(step_word_a_reg)))
        else $error("accumulator step wrong");
    serial_step_b_a: assert property (load_rise && tc_used == `TC_SERIAL_STEP_B |=>
        step_word_b_reg == $past(ser_copy_reg))
        else $error("serial word not moved to step b");
    one_transfer_a: assert property (load_rise |=> !load_rise)
        else $error("two transfers for one strobe");
    par_step_a_a: assert property (load_rise && tc_used[`TC_MOD_BIT] && !tc_used[`TC_SERIAL_BIT] &&
        dest == dest_step_a |=> step_word_a_reg == $past(par_asm_reg))
        else $error("parallel word not moved to step a");
    xfer_hold_a: assert property (!load_rise |=> $stable(step_word_a_reg) && $stable(step_word_b_reg) &&
        $stable(phase_offset_reg) && $stable(quad_amplitude_word_reg))
        else $error("register changed without transfer");
    serial_quiet_a: assert property (ser_tog_sync_reg[2] != ser_tog_sync_reg[1] |=> $stable(ser_copy_reg))
        else $error("serial word taken while bit clock active");
    amp_path_a: assert property (!sleeping && amp_on |=> dac_out == $past(iq_sum))
        else $error("modulated output not iq sum");
    sleep_flag_a: assert property (1'b1 |=> sleep_out == $past(sleeping))
        else $error("sleep flag wrong");
    serial_shift_a: assert property (@(posedge serial_bit_clock_in) disable iff (reset_in)
        1'b1 |=> ser_shift_reg[31:1] == $past(ser_shift_reg[30:0]))
        else $error("serial shift wrong");

endmodule // dds_core
`default_nettype wire

// file: bench/host_model.sv
// Host model driving the parallel bus, transfer pins and serial link
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic sys_clk_in,
    output logic [15:0] data_out,
    output logic write_strobe_n_out,
    output logic chip_select_n_out,
    output logic load_out,
    output logic [3:0] transfer_code_out,
    output logic serial_bit_clock_out,
    output logic serial_data_out
);
    initial begin
        data_out = 16'h0000;
        write_strobe_n_out = 1'b1;
        chip_select_n_out = 1'b1;
        load_out = 1'b0;
        transfer_code_out = 4'h0;
        serial_bit_clock_out = 1'b0;
        serial_data_out = 1'b0;
    end

    // Strobe phases of three cycles; the core synchroniser needs two
    task automatic par_write(input logic [15:0] word);
        @(negedge sys_clk_in);
        chip_select_n_out = 1'b0;
        data_out = word;
        write_strobe_n_out = 1'b0;
        repeat (3) @(negedge sys_clk_in);
        write_strobe_n_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        chip_select_n_out = 1'b1;
        data_out = ~word;
        repeat (2) @(negedge sys_clk_in);
    endtask

    // Code held before the rise and past the fall
    task automatic xfer(input logic [3:0] code);
        @(negedge sys_clk_in);
        transfer_code_out = code;
        @(negedge sys_clk_in);
        load_out = 1'b1;
        repeat (3) @(negedge sys_clk_in);
        load_out = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        transfer_code_out = ~code;
        repeat (12) @(negedge sys_clk_in);
    endtask

    // Bit clock runs only within the frame
    task automatic ser_send(input logic [31:0] word);
        #3;
        for (int i = 31; i >= 0; i--) begin
            serial_data_out = word[i];
            #7.5 serial_bit_clock_out = 1'b1;
            #7.5 serial_bit_clock_out = 1'b0;
        end
        serial_data_out = ~word[0];
        repeat (10) @(negedge sys_clk_in);
    endtask
endmodule // host_model
`default_nettype wire

// file: bench/tb.sv
// Testbench for the synthesis core
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic sys_clk;
    logic reset;
    logic freq_pin;
    logic [15:0] data;
    logic wr_n;
    logic cs_n;
    logic load;
    logic [3:0] code;
    logic sclk;
    logic sdata;
    logic [9:0] dac;
    logic sleep;
    int errors;
    int num_checks;

    host_model host (.sys_clk_in(sys_clk), .data_out(data), .write_strobe_n_out(wr_n),
        .chip_select_n_out(cs_n), .load_out(load), .transfer_code_out(code),
        .serial_bit_clock_out(sclk), .serial_data_out(sdata));
    dds_core dut (.sys_clk_in(sys_clk), .reset_in(reset), .data_in(data), .write_strobe_n_in(wr_n),
        .chip_select_n_in(cs_n), .load_in(load), .transfer_code_in(code), .freq_choice_pin_in(freq_pin),
        .serial_bit_clock_in(sclk), .serial_data_in(sdata), .dac_out(dac), .sleep_out(sleep));

    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] seen);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Output alternates between two samples on successive cycles
    task automatic check_pair(input string what, input logic [9:0] a, input logic [9:0] b);
        logic [9:0] x;
        logic [9:0] y;
        @(negedge sys_clk);
        x = dac;
        @(negedge sys_clk);
        y = dac;
        num_checks++;
        if (!((x === a && y === b) || (x === b && y === a))) begin
            errors++;
            $display("mismatch %s expected %h/%h seen %h/%h", what, a, b, x, y);
        end
    endtask

    // Upper pins carry junk in narrow mode; it must not land
    task automatic load32(input logic wide, input logic [31:0] w, input logic [3:0] tc);
        if (wide) begin
            host.par_write(w[31:16]);
            host.par_write(w[15:0]);
        end else begin
            for (int i = 3; i >= 0; i--) host.par_write({8'ha5, w[i*8 +: 8]});
        end
        host.xfer(tc);
    endtask

    task automatic set_mode(input logic [15:0] m);
        host.par_write(m);
        host.xfer(4'h0);
    endtask

    initial begin
        logic [9:0] held;
        reset = 1'b1;
        freq_pin = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (8) @(negedge sys_clk);
        reset = 1'b0;
        check("reset dac", 10'h000, dac);
        check("reset sleep", 10'h000, {9'h000, sleep});
        load32(1'b0, 32'h0000_0400, 4'ha);
        check("quarter phase", 10'h1ff, dac);
        set_mode(16'h0002);
        check("sleep on", 10'h001, {9'h000, sleep});
        check("sleep dac", 10'h000, dac);
        set_mode(16'h0001);
        check("sleep off", 10'h000, {9'h000, sleep});
        load32(1'b1, 32'h8000_0000, 4'h8);
        check_pair("half step", 10'h1ff, 10'h201);
        fork
            host.ser_send(32'h4000_0000);
            load32(1'b1, 32'h0004_0000, 4'hb);
        join
        host.xfer(4'hd);
        // Quarter step: a zero sample every other cycle, unlike the half step of step_word_a
        freq_pin = 1'b1;
        repeat (10) @(negedge sys_clk);
        held = dac;
        @(negedge sys_clk);
        num_checks++;
        if ((held === 10'h000) === (dac === 10'h000)) begin
            errors++;
            $display("mismatch step b zero pattern expected one zero seen %h/%h", held, dac);
        end
        num_checks++;
        if ((held ^ dac) !== 10'h1ff && (held ^ dac) !== 10'h201) begin
            errors++;
            $display("mismatch step b level expected 1ff/201 seen %h/%h", held, dac);
        end
        // Eighteen quarter steps keep the phase on a half-cycle boundary
        repeat (7) @(negedge sys_clk);
        freq_pin = 1'b0;
        repeat (10) @(negedge sys_clk);
        check_pair("back to a", 10'h1ff, 10'h201);
        set_mode(16'h0005);
        check_pair("sine path", 10'h0ff, 10'h300);
        load32(1'b1, 32'h0000_0100, 4'hb);
        load32(1'b1, 32'h0000_0000, 4'ha);
        check_pair("cosine path", 10'h0ff, 10'h300);
        set_mode(16'h000d);
        check_pair("bypass sync", 10'h0ff, 10'h300);
        summarize();
    end

    initial begin
        #200000;
        errors++;
        $display("mismatch watchdog expected done seen hang");
        summarize();
    end
endmodule // tb
`default_nettype wire
